// ---- hw/sgp_pkg.sv ----
// Constants of the six-pin general-purpose port: register indices,
// byte addresses, field layout and reset values.
// Assumes a 32-bit AHB-Lite bus with one register per aligned word.
package sgp_pkg;

  // Pin count and register width
  localparam int unsigned SGP_PINS   = 6;
  localparam int unsigned SGP_REG_W  = 8;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] SGP_IDX_ENABLE = 8'h55;
  localparam logic [7:0] SGP_IDX_DIR    = 8'h56;
  localparam logic [7:0] SGP_IDX_DRV    = 8'h57;
  localparam logic [7:0] SGP_IDX_IN     = 8'h58;
  localparam logic [7:0] SGP_IDX_OUT    = 8'h59;

  localparam logic [31:0] SGP_ADDR_ENABLE = 32'({SGP_IDX_ENABLE, 2'b00});
  localparam logic [31:0] SGP_ADDR_DIR    = 32'({SGP_IDX_DIR, 2'b00});
  localparam logic [31:0] SGP_ADDR_DRV    = 32'({SGP_IDX_DRV, 2'b00});
  localparam logic [31:0] SGP_ADDR_IN     = 32'({SGP_IDX_IN, 2'b00});
  localparam logic [31:0] SGP_ADDR_OUT    = 32'({SGP_IDX_OUT, 2'b00});

  // Pin fields occupy bits 5..0 of every register
  localparam int unsigned SGP_PIN_LSB = 0;
  localparam int unsigned SGP_PIN_MSB = 5;

  // Reset values
  localparam logic [5:0] SGP_RST_ENABLE = 6'h00;
  localparam logic [5:0] SGP_RST_DIR    = 6'h3F;
  localparam logic [5:0] SGP_RST_DRV    = 6'h00;
  localparam logic [5:0] SGP_RST_IN     = 6'h00;
  localparam logic [5:0] SGP_RST_OUT    = 6'h00;

  // Direction and driver-type encodings of one bit
  localparam logic SGP_DIR_INPUT   = 1'b0;
  localparam logic SGP_DIR_OUTPUT  = 1'b1;
  localparam logic SGP_DRV_PUSH    = 1'b0;
  localparam logic SGP_DRV_OPEN    = 1'b1;

  // AHB transfer type bit that marks NONSEQ or SEQ
  localparam int unsigned SGP_HTRANS_ACTIVE = 1;

endpackage : sgp_pkg

// ---- hw/sgp_port.sv ----
// Six-pin general-purpose port with its register file on AHB-Lite.
// Assumes the pins are asynchronous board signals and that the bus
// issues single whole-word transfers; hready is the bus ready.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module sgp_port (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Pins, three signals each; oe_n low while the pin is driven
  input  wire logic [5:0]  pin_in,
  output logic      [5:0]  pin_out,
  output logic      [5:0]  pin_oe_n
);

  localparam int unsigned MSB = sgp_pkg::SGP_PIN_MSB;
  localparam int unsigned LSB = sgp_pkg::SGP_PIN_LSB;

  // Register state
  logic [5:0] pin_enable_q;
  logic [5:0] pin_direction_q;
  logic [5:0] pin_driver_type_q;
  logic [5:0] pin_output_value_q;
  logic [5:0] pin_input_level;

  // Bus pipeline state
  logic        wr_pend_q;
  logic [31:0] wr_addr_q;
  logic        rd_pend_q;
  logic [31:0] rdata_q;

  // Address-phase decode
  logic        addr_phase;
  logic        rd_take;
  logic        wr_take;
  logic [5:0]  wr_bits;
  logic [5:0]  rd_bits;
  logic        rd_hit;

  // Per-register selects of the address in flight
  logic        sel_enable;
  logic        sel_dir;
  logic        sel_drv;
  logic        sel_in;
  logic        sel_out;

  // Per-register strobes of the write waiting for its data
  logic        wsel_enable;
  logic        wsel_dir;
  logic        wsel_drv;
  logic        wsel_out;
  logic        fwd_hit;

  // Drive computation
  logic [5:0]  drive_en;
  logic [5:0]  out_d;
  logic [5:0]  oe_n_d;

  // Zero-wait slave that always answers OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  assign addr_phase = hsel && hready && htrans[sgp_pkg::SGP_HTRANS_ACTIVE];
  assign rd_take    = addr_phase && !hwrite;
  assign wr_take    = addr_phase && hwrite;
  assign wr_bits    = hwdata[MSB:LSB];

  // Address in flight, decoded; the read mux decodes haddr itself, only sel_in is used (forwarding)
  assign sel_enable = (haddr == sgp_pkg::SGP_ADDR_ENABLE);
  assign sel_dir    = (haddr == sgp_pkg::SGP_ADDR_DIR);
  assign sel_drv    = (haddr == sgp_pkg::SGP_ADDR_DRV);
  assign sel_in     = (haddr == sgp_pkg::SGP_ADDR_IN);
  assign sel_out    = (haddr == sgp_pkg::SGP_ADDR_OUT);

  // Pending write, decoded from the latched address
  assign wsel_enable = wr_pend_q && (wr_addr_q == sgp_pkg::SGP_ADDR_ENABLE);
  assign wsel_dir    = wr_pend_q && (wr_addr_q == sgp_pkg::SGP_ADDR_DIR);
  assign wsel_drv    = wr_pend_q && (wr_addr_q == sgp_pkg::SGP_ADDR_DRV);
  assign wsel_out    = wr_pend_q && (wr_addr_q == sgp_pkg::SGP_ADDR_OUT);

  // input register is never a forwarding source
  assign fwd_hit = wr_pend_q && (wr_addr_q == haddr) && !sel_in;

  // Write data arrives a cycle after its address
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= wr_take;
    end
  end

  // Address kept for the data phase; only read while wr_pend_q is set
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_addr_q <= 32'h0000_0000;
    end else begin
      wr_addr_q <= haddr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= rd_take;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_enable_q <= sgp_pkg::SGP_RST_ENABLE;
    end else if (wsel_enable) begin
      pin_enable_q <= wr_bits;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_direction_q <= sgp_pkg::SGP_RST_DIR;
    end else if (wsel_dir) begin
      pin_direction_q <= wr_bits;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_driver_type_q <= sgp_pkg::SGP_RST_DRV;
    end else if (wsel_drv) begin
      pin_driver_type_q <= wr_bits;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_output_value_q <= sgp_pkg::SGP_RST_OUT;
    end else if (wsel_out) begin
      pin_output_value_q <= wr_bits;
    end
  end

  sgp_sync #(
    .WIDTH    (sgp_pkg::SGP_PINS)
  ) u_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (pin_in),
    .level_q  (pin_input_level)
  );

  // Read mux; a write still in its data phase is forwarded so that a
  // read right behind it sees the new value.
  always_comb begin
    rd_hit  = 1'b1;
    rd_bits = 6'h00;
    unique case (haddr)
      sgp_pkg::SGP_ADDR_ENABLE: rd_bits = pin_enable_q;
      sgp_pkg::SGP_ADDR_DIR:    rd_bits = pin_direction_q;
      sgp_pkg::SGP_ADDR_DRV:    rd_bits = pin_driver_type_q;
      sgp_pkg::SGP_ADDR_IN:     rd_bits = pin_input_level;
      sgp_pkg::SGP_ADDR_OUT:    rd_bits = pin_output_value_q;
      default: begin
        rd_hit  = 1'b0;
        rd_bits = 6'h00;
      end
    endcase
    if (rd_hit && fwd_hit) begin
      rd_bits = wr_bits;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_q <= {26'h000_0000, rd_bits};
    end else if (rd_pend_q) begin
      rdata_q <= rdata_q;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign drive_en = pin_enable_q &
                    (pin_direction_q & {6{sgp_pkg::SGP_DIR_OUTPUT}});

  always_comb begin
    out_d  = 6'h00;
    oe_n_d = 6'h3F;
    for (int i = 0; i < sgp_pkg::SGP_PINS; i++) begin
      if (drive_en[i]) begin
        if (pin_driver_type_q[i] == sgp_pkg::SGP_DRV_PUSH) begin
          out_d[i]  = pin_output_value_q[i];
          oe_n_d[i] = 1'b0;
        end else begin
          out_d[i]  = 1'b0;
          oe_n_d[i] = pin_output_value_q[i];
        end
      end
    end
  end

  // Registered pin outputs; released during reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_out  <= 6'h00;
      pin_oe_n <= 6'h3F;
    end else begin
      pin_out  <= out_d;
      pin_oe_n <= oe_n_d;
    end
  end

endmodule // sgp_port

// ---- hw/sgp_sync.sv ----
// Synchroniser for a vector of asynchronous pin levels.
// Three stages and an output flop per bit; the output follows only once the second and
// third stages agree. Assumes a synchronous active-high reset.
`timescale 1ns/1ps
module sgp_sync #(
  parameter int unsigned WIDTH = 6
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_q
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;

  // First stage is read by the second stage only
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_q   <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
    end else begin
      meta_q   <= async_in;
      stage2_q <= meta_q;
      stage3_q <= stage2_q;
    end
  end

  // Per-bit acceptance once two settled stages agree
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      level_q <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_q[i] == stage3_q[i]) begin
          level_q[i] <= stage3_q[i];
        end
      end
    end
  end

endmodule // sgp_sync

// ---- test/sgp_board.sv ----
// Board side of the six pins: optional board driver, else pull-up.
// Assumes no contention: the board drives only released pins.
`timescale 1ns/1ps
module sgp_board (
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe_n,
  input  wire logic [5:0] ext_en,
  input  wire logic [5:0] ext_lvl,
  output logic      [5:0] pin_in
);
  // released line: board level or pull-up
  assign pin_in = (~pin_oe_n & pin_out)
    | (pin_oe_n & ((ext_en & ext_lvl) | ~ext_en));
endmodule // sgp_board

// ---- test/sgp_port_chk.sv ----
// Checker for sgp_port: shadows registers from bus writes.
// Sees only the top ports; bound at the foot.
`timescale 1ns/1ps
module sgp_chk (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic        hwrite,
  input wire logic [1:0]  htrans,
  input wire logic [31:0] haddr,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic [5:0]  pin_in,
  input wire logic [5:0]  pin_out,
  input wire logic [5:0]  pin_oe_n
);
  logic [31:0] a_q;
  logic        wr_q, rd_q, tk;
  logic [5:0]  en_q, dir_q, drv_q, out_q, on_x, oe_x, hi_x;
  assign tk   = hsel & hready & htrans[1];
  assign on_x = en_q & dir_q;
  assign oe_x = ~(on_x & ~(drv_q & out_q));
  assign hi_x = on_x & ~drv_q & out_q;
  always_ff @(posedge ref_clk) begin
    wr_q <= !reset & tk & hwrite;
    rd_q <= !reset & tk & !hwrite;
    a_q  <= haddr;
  end
  // Shadow lands with the data phase, like the design
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      en_q  <= 6'h00;
      dir_q <= 6'h3f;
      drv_q <= 6'h00;
      out_q <= 6'h00;
    end else if (wr_q) begin
      case (a_q)
        sgp_pkg::SGP_ADDR_ENABLE: en_q <= hwdata[5:0];
        sgp_pkg::SGP_ADDR_DIR:    dir_q <= hwdata[5:0];
        sgp_pkg::SGP_ADDR_DRV:    drv_q <= hwdata[5:0];
        sgp_pkg::SGP_ADDR_OUT:    out_q <= hwdata[5:0];
        default: ;
      endcase
    end
  end
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_oe_map: assert property (pin_oe_n == $past(oe_x))
    else $error("pin enable wrong");
  a_drive_high: assert property ((pin_out & ~pin_oe_n) == $past(hi_x))
    else $error("pin level wrong");
  a_off_quiet: assert property ((pin_out & ~$past(on_x)) == 6'h00)
    else $error("idle pin driven");
  a_read_enable: assert property (rd_q && a_q == sgp_pkg::SGP_ADDR_ENABLE
    |-> hrdata[5:0] == en_q) else $error("enable read wrong");
  a_input_seen: assert property ($stable(pin_in)[*6] ##0 tk && !hwrite
    && haddr == sgp_pkg::SGP_ADDR_IN |=> hrdata == {26'h0, $past(pin_in)})
    else $error("input level wrong");
  a_upper_zero: assert property (hrdata[31:6] == 26'h0)
    else $error("reserved bits set");
  a_reset_pins: assert property (disable iff (1'b0) reset
    |=> pin_oe_n == 6'h3f && pin_out == 6'h00) else $error("pins at reset");
  a_reset_read: assert property (disable iff (1'b0) reset
    |=> hrdata == 32'h0) else $error("read data at reset");
  c_write_out: cover property (wr_q && a_q == sgp_pkg::SGP_ADDR_OUT);
  c_open_low: cover property (|(on_x & drv_q & ~out_q));
  c_read: cover property (rd_q);
endmodule // sgp_chk
bind sgp_port sgp_chk i_chk (.ref_clk, .reset, .hsel, .hready, .hwrite,
  .htrans, .haddr, .hwdata, .hrdata, .pin_in, .pin_out, .pin_oe_n);

// ---- test/tb_top.sv ----
// Bench for sgp_port: AHB-Lite master tasks, board model on the pins.
// Assumes zero-wait slave; waits on hready anyway.
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [31:0] a, d; logic [5:0] e;} sgp_row_t;
  logic        ref_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic        hready, hresp;
  logic [5:0]  pin_in, pin_out, pin_oe_n;
  logic [5:0]  ext_en = 6'h3f, ext_lvl = 6'h2c;
  int          failures = 0, cmp_count = 0;
  sgp_row_t    rows[5] = '{
    '{sgp_pkg::SGP_ADDR_ENABLE, 32'hffff_ffff, 6'h3f},
    '{sgp_pkg::SGP_ADDR_DIR, 32'hffff_ffdf, 6'h1f},
    '{sgp_pkg::SGP_ADDR_DRV, 32'hca, 6'h0a},
    '{sgp_pkg::SGP_ADDR_OUT, 32'h33, 6'h33},
    '{32'h168, 32'h3f, 6'h00}};
  always #2 ref_clk = ~ref_clk;
  sgp_port i_dut (.ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .pin_in, .pin_out,
    .pin_oe_n);
  sgp_board i_board (.pin_out, .pin_oe_n, .ext_en, .ext_lvl, .pin_in);
  task automatic xfer(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Run takes about 70 cycles
  initial begin
    #40000;
    failures++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].a, rows[i].d);
      xfer(1'b0, rows[i].a, 32'h0);
      check("readback", rd, {26'h0, rows[i].e});
    end
    // Pins 1,3,5 push-pull, 2 open-drain high, 4 open-drain low, 6 input
    #1;
    check("oe_n", {26'h0, pin_oe_n}, 32'h22);
    check("drive", {26'h0, pin_out & ~pin_oe_n}, 32'h11);
    repeat (8) @(posedge ref_clk);
    xfer(1'b1, sgp_pkg::SGP_ADDR_IN, 32'h0);
    check("hresp", {31'h0, hresp}, 32'h0);
    ext_lvl <= 6'h00;
    xfer(1'b0, sgp_pkg::SGP_ADDR_IN, 32'h0);
    check("input old", rd, 32'h31);
    repeat (8) @(posedge ref_clk);
    xfer(1'b0, sgp_pkg::SGP_ADDR_IN, 32'h0);
    check("input new", rd, 32'h11);
    reset <= 1'b1;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    check("oe_n reset", {26'h0, pin_oe_n}, 32'h3f);
    check("out reset", {26'h0, pin_out}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, rows[i].a, 32'h0);
      check("reset value", rd, (i == 1) ? 32'h3f : 32'h0);
    end
    end_of_test();
  end
endmodule // tb_top
